// ==== oc7_defines.svh ====
/*
  Offsets, field positions, reset values and codes for the channel 7
  configuration and status registers.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef OC7_DEFINES_SVH
`define OC7_DEFINES_SVH

// Register offsets on the configuration port
`define OC7_ADDR_CTRL 8'h12
`define OC7_ADDR_DIV 8'h13
`define OC7_ADDR_FRAC 8'h14
`define OC7_ADDR_STATUS 8'h15

// Reset values of the writable registers
`define OC7_RST_CTRL 16'h0652
`define OC7_RST_DIV 16'h0008
`define OC7_RST_FRAC 16'h0000

// Writable bit masks; reserved bits are dropped on write
`define OC7_MASK_CTRL 16'h1fdf
`define OC7_MASK_DIV 16'h0fff
`define OC7_MASK_FRAC 16'hffff

// Control register fields
`define OC7_PRESCALE_MSB 12
`define OC7_PRESCALE_LSB 10
`define OC7_FRAC_EN_BIT 9
`define OC7_EDGE_BIT 8
`define OC7_NEG_EN_BIT 7
`define OC7_POS_EN_BIT 6
`define OC7_DRV_MSB 4
`define OC7_DRV_LSB 3
`define OC7_MODE_MSB 2
`define OC7_MODE_LSB 1
`define OC7_SUPPLY_BIT 0

// Divider register fields
`define OC7_INTDIV_MSB 11
`define OC7_INTDIV_LSB 4
`define OC7_FRACHI_MSB 3
`define OC7_FRACHI_LSB 0

// Status register fields
`define OC7_ST_UNLOCK_BIT 2
`define OC7_ST_LOS_BIT 1
`define OC7_ST_SEL_BIT 0

// Prescale codes
`define OC7_PRE_DIV2 3'h0
`define OC7_PRE_DIV3 3'h1
`define OC7_PRE_DIV1 3'h7

`endif

// ==== oc7_pkg.sv ====
/*
  Types for the channel 7 configuration block.
  Assumes oc7_defines.svh is on the include path.
*/
package oc7_pkg;
  `include "oc7_defines.svh"

  typedef enum logic [1:0] {
    OC7_DRV_LVDS = 2'h0,
    OC7_DRV_LVCMOS = 2'h2,
    OC7_DRV_HCSL = 2'h3
  } oc7_drv_type;

  typedef enum logic [1:0] {
    OC7_OUT_OFF = 2'h0,
    OC7_OUT_TOGGLE = 2'h1,
    OC7_OUT_LOW = 2'h2,
    OC7_OUT_HIGH = 2'h3
  } oc7_mode_type;

  // Decoded settings handed to the channel 7 datapath
  typedef struct packed {
    logic frac_path_enable;
    logic [1:0] prescale_ratio;
    logic prescale_reserved;
    logic single_ended_edge_rate;
    logic single_ended_neg_enable;
    logic single_ended_pos_enable;
    oc7_drv_type driver_type_sel;
    oc7_mode_type channel_output_state;
    logic output_supply_range;
    logic [8:0] integer_divide_ratio;
    logic [19:0] fraction_divide_value;
  } oc7_cfg_type;
endpackage

// ==== oc7_config_regs.sv ====
/*
  Channel 7 output configuration registers and the device status word,
  with decoded settings for the output datapath.
  Assumes a serial port front end on the same clock that presents one
  register access per strobe, and status levels from the PLL domain.
*/
`timescale 1ns/10ps
`include "oc7_defines.svh"

module oc7_config_regs
  import oc7_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_pll_locked,
  input wire logic i_reference_missing_flag,
  input wire logic i_ref_secondary,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic o_lock_status,
  output oc7_cfg_type o_ch7_cfg
);

  // Prescale code to ratio; reserved codes fall back to one
  function automatic logic [2:0] prescale_decode(input logic [2:0] code);
    case (code)
      `OC7_PRE_DIV2: prescale_decode = {1'b0, 2'h2};
      `OC7_PRE_DIV3: prescale_decode = {1'b0, 2'h3};
      `OC7_PRE_DIV1: prescale_decode = {1'b0, 2'h1};
      default: prescale_decode = {1'b1, 2'h1};
    endcase
  endfunction

  logic [15:0] ctrl;
  logic [15:0] divider;
  logic [15:0] fraction;
  logic [15:0] next_ctrl;
  logic [15:0] next_divider;
  logic [15:0] next_fraction;

  // Writable registers; the status offset has no storage at all
  always_comb begin
    next_ctrl = ctrl;
    next_divider = divider;
    next_fraction = fraction;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `OC7_ADDR_CTRL: next_ctrl = i_reg_wdata & `OC7_MASK_CTRL;
        `OC7_ADDR_DIV: next_divider = i_reg_wdata & `OC7_MASK_DIV;
        `OC7_ADDR_FRAC: next_fraction = i_reg_wdata & `OC7_MASK_FRAC;
        default: next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl <= `OC7_RST_CTRL;
      divider <= `OC7_RST_DIV;
      fraction <= `OC7_RST_FRAC;
    end else begin
      ctrl <= next_ctrl;
      divider <= next_divider;
      fraction <= next_fraction;
    end
  end

  // Status levels come from the PLL domain, so two stages each
  logic [2:0] status_meta;
  logic [2:0] status_sync;
  logic [2:0] next_status_meta;

  always_comb begin
    next_status_meta = {i_pll_locked, i_reference_missing_flag, i_ref_secondary};
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status_meta <= 3'h0;
      status_sync <= 3'h0;
    end else begin
      status_meta <= next_status_meta;
      status_sync <= status_meta;
    end
  end

  // Status word: unlock is the inverse of the lock level
  logic [15:0] status_word;
  always_comb begin
    status_word = 16'h0000;
    status_word[`OC7_ST_UNLOCK_BIT] = ~status_sync[2];
    status_word[`OC7_ST_LOS_BIT] = status_sync[1];
    status_word[`OC7_ST_SEL_BIT] = status_sync[0];
  end

  // Read path, one cycle after the strobe; unmapped offsets read zero
  logic [15:0] next_rdata;
  logic next_rvalid;
  logic next_lock;

  always_comb begin
    next_rvalid = i_reg_rd;
    next_rdata = o_reg_rdata;
    next_lock = status_sync[2]; // Pin polarity: high means locked
    if (i_reg_rd) begin
      case (i_reg_addr)
        `OC7_ADDR_CTRL: next_rdata = ctrl;
        `OC7_ADDR_DIV: next_rdata = divider;
        `OC7_ADDR_FRAC: next_rdata = fraction;
        `OC7_ADDR_STATUS: next_rdata = status_word;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
      o_lock_status <= 1'b0;
    end else begin
      o_reg_rdata <= next_rdata;
      o_reg_rvalid <= next_rvalid;
      o_lock_status <= next_lock;
    end
  end

  // Decoded settings, registered so the datapath sees clean levels
  oc7_cfg_type next_cfg;
  logic [2:0] pre;

  always_comb begin
    pre = prescale_decode(ctrl[`OC7_PRESCALE_MSB:`OC7_PRESCALE_LSB]);
    next_cfg.frac_path_enable = ctrl[`OC7_FRAC_EN_BIT];
    // Bypass forces unity, so a stale code cannot disturb the path
    next_cfg.prescale_ratio = ctrl[`OC7_FRAC_EN_BIT] ? pre[1:0] : 2'h1;
    next_cfg.prescale_reserved = ctrl[`OC7_FRAC_EN_BIT] & pre[2];
    next_cfg.single_ended_edge_rate = ctrl[`OC7_EDGE_BIT];
    next_cfg.single_ended_pos_enable = ctrl[`OC7_POS_EN_BIT];
    // A lone negative enable is a software slip; keep the side off
    next_cfg.single_ended_neg_enable = ctrl[`OC7_NEG_EN_BIT] & ctrl[`OC7_POS_EN_BIT];
    case (ctrl[`OC7_DRV_MSB:`OC7_DRV_LSB])
      2'h2: next_cfg.driver_type_sel = OC7_DRV_LVCMOS;
      2'h3: next_cfg.driver_type_sel = OC7_DRV_HCSL;
      default: next_cfg.driver_type_sel = OC7_DRV_LVDS;
    endcase
    next_cfg.channel_output_state = oc7_mode_type'(ctrl[`OC7_MODE_MSB:`OC7_MODE_LSB]);
    next_cfg.output_supply_range = ctrl[`OC7_SUPPLY_BIT];
    next_cfg.integer_divide_ratio =
      {1'b0, divider[`OC7_INTDIV_MSB:`OC7_INTDIV_LSB]} + 9'h001;
    next_cfg.fraction_divide_value =
      {divider[`OC7_FRACHI_MSB:`OC7_FRACHI_LSB], fraction};
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      // Unity ratios while held, so no illegal zero divide leaks out
      o_ch7_cfg <= '0;
      o_ch7_cfg.prescale_ratio <= 2'h1;
      o_ch7_cfg.integer_divide_ratio <= 9'h001;
    end else begin
      o_ch7_cfg <= next_cfg;
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence ctrl_write_s;
    i_reg_wr && i_reg_addr == `OC7_ADDR_CTRL;
  endsequence

  prescale_bypass_a: assert property (!o_ch7_cfg.frac_path_enable |->
    o_ch7_cfg.prescale_ratio == 2'h1) else $error("prescaler not bypassed");
  prescale_three_a: assert property (
    ctrl[`OC7_FRAC_EN_BIT] && ctrl[`OC7_PRESCALE_MSB:`OC7_PRESCALE_LSB] == 3'h1
    |=> o_ch7_cfg.prescale_ratio == 2'h3) else $error("code 001 not divide by three");
  frac_enable_a: assert property (ctrl_write_s |->
    ##2 o_ch7_cfg.frac_path_enable == $past(i_reg_wdata[`OC7_FRAC_EN_BIT], 2))
    else $error("fraction enable not applied two cycles after write");
  neg_gate_a: assert property (o_ch7_cfg.single_ended_neg_enable |->
    o_ch7_cfg.single_ended_pos_enable) else $error("negative side on alone");
  edge_rate_a: assert property ($changed(ctrl[`OC7_EDGE_BIT]) |=>
    o_ch7_cfg.single_ended_edge_rate == $past(ctrl[`OC7_EDGE_BIT]))
    else $error("edge rate not following control");
  driver_map_a: assert property (ctrl[`OC7_DRV_MSB] == 1'b0 |=>
    o_ch7_cfg.driver_type_sel == OC7_DRV_LVDS) else $error("low codes not LVDS");
  mode_map_a: assert property (1'b1 |=> o_ch7_cfg.channel_output_state ==
    $past(ctrl[`OC7_MODE_MSB:`OC7_MODE_LSB])) else $error("output state wrong");
  int_div_a: assert property (1'b1 |=> o_ch7_cfg.integer_divide_ratio ==
    9'($past(divider[`OC7_INTDIV_MSB:`OC7_INTDIV_LSB]) + 9'h001))
    else $error("integer ratio is not value plus one");
  fraction_a: assert property (i_reg_wr && i_reg_addr == `OC7_ADDR_FRAC |->
    ##2 o_ch7_cfg.fraction_divide_value[15:0] == $past(i_reg_wdata, 2))
    else $error("fraction low half not applied");
  status_rsvd_a: assert property (i_reg_rd && i_reg_addr == `OC7_ADDR_STATUS |=>
    o_reg_rvalid && o_reg_rdata[15:3] == 13'h0000) else $error("status reserved set");
  unlock_bit_a: assert property (i_reg_rd && i_reg_addr == `OC7_ADDR_STATUS |=>
    o_reg_rdata[`OC7_ST_UNLOCK_BIT] != o_lock_status) else $error("unlock polarity");
  ro_write_a: assert property (i_reg_wr && i_reg_addr == `OC7_ADDR_STATUS |=>
    $stable(ctrl) && $stable(divider) && $stable(fraction))
    else $error("status write changed a register");

endmodule // oc7_config_regs

// ==== oc7_host_model.sv ====
/*
  Host model for the channel 7 register port: one-cycle write and read
  strobes, launched on falling edges.
  Assumes the bench clock and a read answer one cycle after the strobe.
*/
`timescale 1ns/10ps
module oc7_host_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [15:0] o_reg_wdata
);
  // Port quiet at time zero
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 16'h0000;
  end

  // Lines inverted after use so a stale address is never trusted
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_core_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask

  // Answer taken in the cycle after the strobe edge
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_core_clk);
    d = i_reg_rdata;
    v = i_reg_rvalid;
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
  endtask
endmodule // oc7_host_model

// ==== test_output_ch7_config_status_regs.sv ====
/*
  Self-checking bench for the channel 7 register bank.
  Assumes oc7_pkg, oc7_config_regs and oc7_host_model are compiled first.
*/
`timescale 1ns/10ps
`include "oc7_defines.svh"
module test_output_ch7_config_status_regs;
  import oc7_pkg::*;
  logic i_core_clk, i_reset_n, pll_locked, ref_missing, ref_secondary;
  logic [7:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, lock_status, vld;
  logic [15:0] reg_wdata, reg_rdata, rd;
  oc7_cfg_type cfg;
  int err_count, samples_checked, cycles;
  logic [2:0] pc [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  logic [1:0] pr [4] = '{2'h2, 2'h3, 2'h1, 2'h1};

  oc7_config_regs dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_reg_addr(reg_addr),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .i_pll_locked(pll_locked),
    .i_reference_missing_flag(ref_missing), .i_ref_secondary(ref_secondary),
    .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .o_lock_status(lock_status),
    .o_ch7_cfg(cfg));
  oc7_host_model host (.i_core_clk(i_core_clk), .i_reg_rdata(reg_rdata),
    .i_reg_rvalid(reg_rvalid), .o_reg_addr(reg_addr), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
    .o_reg_wdata(reg_wdata));

  // 125 MHz core clock
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Read with answer and data compared
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    host.rd_reg(a, rd, vld);
    chk({19'h0, vld}, 20'h1);
    chk({4'h0, rd}, {4'h0, exp});
    // Answer stands one cycle only
    @(negedge i_core_clk);
    chk({19'h0, reg_rvalid}, 20'h0);
  endtask

  // Control write, then one edge for the decode to land
  task automatic wcfg(input logic [15:0] d);
    host.wr_reg(`OC7_ADDR_CTRL, d);
    @(negedge i_core_clk);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the hundred or so cycles needed
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end

  initial begin
    i_reset_n = 1'b0;
    pll_locked = 1'b0;
    ref_missing = 1'b0;
    ref_secondary = 1'b0;
    repeat (16) @(posedge i_core_clk);
    @(negedge i_core_clk) i_reset_n = 1'b1;
    @(negedge i_core_clk);
    chk(cfg.integer_divide_ratio, 20'h1);
    chk(cfg.fraction_divide_value, 20'h80000);
    chk({cfg.frac_path_enable, cfg.prescale_ratio}, 20'h7);
    chk({cfg.driver_type_sel, cfg.channel_output_state}, 20'h9);
    rchk(`OC7_ADDR_CTRL, `OC7_RST_CTRL);
    rchk(`OC7_ADDR_DIV, `OC7_RST_DIV);
    rchk(`OC7_ADDR_FRAC, `OC7_RST_FRAC);
    // All ones: reserved bits must be dropped, every field set
    wcfg(16'hffff);
    rchk(`OC7_ADDR_CTRL, 16'h1fdf);
    chk(cfg.frac_path_enable, 20'h1);
    chk(cfg.single_ended_edge_rate, 20'h1);
    chk({cfg.single_ended_neg_enable, cfg.single_ended_pos_enable}, 20'h3);
    chk(cfg.output_supply_range, 20'h1);
    // Negative side alone stays off
    wcfg(16'h0080);
    chk({cfg.single_ended_neg_enable, cfg.single_ended_pos_enable}, 20'h0);
    chk({cfg.frac_path_enable, cfg.single_ended_edge_rate, cfg.output_supply_range}, 20'h0);
    // Every driver type and output state code
    for (int i = 0; i < 4; i++) begin
      wcfg(16'((i << 3) | (i << 1)));
      chk(cfg.driver_type_sel, (i < 2) ? 20'h0 : 20'(i));
      chk(cfg.channel_output_state, 20'(i));
    end
    // Prescale codes with the fractional path on, one reserved
    for (int i = 0; i < 4; i++) begin
      wcfg({3'h0, pc[i], 1'b1, 9'h000});
      chk(cfg.prescale_ratio, 20'(pr[i]));
      chk(cfg.prescale_reserved, (i == 2) ? 20'h1 : 20'h0);
    end
    wcfg({3'h0, 3'h1, 1'b0, 9'h000});
    chk({cfg.prescale_reserved, cfg.prescale_ratio}, 20'h1);
    // Divider and split fraction
    host.wr_reg(`OC7_ADDR_DIV, 16'hffff);
    host.wr_reg(`OC7_ADDR_FRAC, 16'h1234);
    @(negedge i_core_clk);
    rchk(`OC7_ADDR_DIV, 16'h0fff);
    chk(cfg.integer_divide_ratio, 20'h100);
    chk(cfg.fraction_divide_value, 20'hf1234);
    // Status word, including an ignored write
    pll_locked = 1'b1;
    ref_secondary = 1'b1;
    repeat (4) @(negedge i_core_clk);
    rchk(`OC7_ADDR_STATUS, 16'h0001);
    chk(lock_status, 20'h1);
    host.wr_reg(`OC7_ADDR_STATUS, 16'hffff);
    rchk(`OC7_ADDR_STATUS, 16'h0001);
    rchk(`OC7_ADDR_CTRL, 16'h0400);
    pll_locked = 1'b0;
    ref_missing = 1'b1;
    ref_secondary = 1'b0;
    repeat (4) @(negedge i_core_clk);
    rchk(`OC7_ADDR_STATUS, 16'h0006);
    chk(lock_status, 20'h0);
    rchk(8'h00, 16'h0000);
    results();
  end
endmodule // test_output_ch7_config_status_regs
